// *** aum_pkg.sv ***
// Package of constants for the alarm and upset monitor
package aum_pkg;

  // ****************************************
  // Alarm source layout
  // ****************************************
  localparam int unsigned NUM_ALARMS = 5;
  localparam int unsigned ALM_PLL    = 0;
  localparam int unsigned ALM_LINK   = 1;
  localparam int unsigned ALM_REALGN = 2;
  localparam int unsigned ALM_OSC    = 3;
  localparam int unsigned ALM_CLK    = 4;

  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int unsigned ACC_W = 32;
  localparam int unsigned CLK_W = 4;
  localparam logic [NUM_ALARMS-1:0] STATUS_RST = 5'h0_0;
  localparam logic [NUM_ALARMS-1:0] MASK_RST   = 5'h1_F;

  // Pin function select values
  localparam logic PIN_SEL_ALARM = 1'b1;

  // Oscillator synchronization source
  typedef enum logic {
    AUM_SYNC_SYSREF,
    AUM_SYNC_LINK_START
  } aum_sync_src_t;

endpackage : aum_pkg

// *** aum_clk_cmp.sv ***
// Half-rate clock comparator for the clock upset detector
module aum_clk_cmp
  import aum_pkg::*;
(
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Compared clocks
  input  wire logic [CLK_W-1:0] clk_state_a,
  input  wire logic [CLK_W-1:0] clk_state_b,
  input  wire logic             compare_ok,
  // Result
  output logic                  clk_mismatch
);

  // ****************************************
  // Half-rate phase
  // ****************************************
  logic half_phase_r;
  logic mis_seen_r;
  wire  differ = compare_ok && (clk_state_a != clk_state_b);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      half_phase_r <= 1'b0;
      mis_seen_r   <= 1'b0;
      clk_mismatch <= 1'b0;
    end else begin
      half_phase_r <= ~half_phase_r;
      // Any difference inside a half-rate cycle counts, so accumulate both halves
      mis_seen_r   <= half_phase_r ? 1'b0 : differ;
      // Gated again at the end so a half seen before the link dropped is not reported
      clk_mismatch <= half_phase_r && (mis_seen_r || differ) && compare_ok;
    end
  end

endmodule : aum_clk_cmp

// *** aum_alarm_monitor.sv ***
// Alarm monitor top: sticky alarm flags, masking, summary and status pin
module aum_alarm_monitor
  import aum_pkg::*;
(
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  // Alarm causes from the core, same clock
  input  wire logic                  serdes_pll_unlocked,
  input  wire logic                  link_not_in_data,
  input  wire logic                  sysref_realign,
  // Oscillator accumulators
  input  wire logic [ACC_W-1:0]      chan_a_phase_acc,
  input  wire logic [ACC_W-1:0]      chan_b_phase_acc,
  input  wire logic                  osc_sync_sysref,
  input  wire logic                  osc_sync_link_start,
  input  wire aum_sync_src_t         osc_sync_source,
  // Internal clocks of both channels
  input  wire logic [CLK_W-1:0]      chan_a_clk_state,
  input  wire logic [CLK_W-1:0]      chan_b_clk_state,
  // Configuration
  input  wire logic                  serial_link_enable,
  input  wire logic                  chan_a_power_down,
  input  wire logic                  chan_b_power_down,
  input  wire logic [NUM_ALARMS-1:0] alarm_mask,
  input  wire logic                  status_pin_select,
  // Host clearing write
  input  wire logic                  clear_write,
  input  wire logic [NUM_ALARMS-1:0] clear_data,
  // Status
  output logic [NUM_ALARMS-1:0]      alarm_status_flags,
  output logic                       summary_alarm,
  output logic                       calibration_status_pin,
  output logic                       oscillator_upset_flag,
  output logic                       clock_upset_flag
);

  // ****************************************
  // Comparison gating
  // ****************************************
  // No valid comparison exists with a channel down or the link held in reset
  wire compare_ok = serial_link_enable && !chan_a_power_down && !chan_b_power_down;

  logic osc_synced_r;
  logic osc_synced_nxt;
  wire  sync_event = (osc_sync_source == AUM_SYNC_SYSREF) ? osc_sync_sysref
                                                          : osc_sync_link_start;

  // Losing a valid comparison drops the sync, so a re-sync is needed afterwards
  assign osc_synced_nxt = !compare_ok ? 1'b0 : (osc_synced_r || sync_event);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      osc_synced_r <= 1'b0;
    end else begin
      osc_synced_r <= osc_synced_nxt;
    end
  end

  // Channel B may legally differ only in which index it selects, and the
  // accumulators compared here are per index, so select pins do not matter
  wire osc_mismatch = compare_ok && osc_synced_r
                      && (chan_a_phase_acc != chan_b_phase_acc);

  // ****************************************
  // Clock comparator
  // ****************************************
  logic clk_mismatch;

  aum_clk_cmp u_clk_cmp (
    .clock        (clock),
    .rst_n        (rst_n),
    .clk_state_a  (chan_a_clk_state),
    .clk_state_b  (chan_b_clk_state),
    .compare_ok   (compare_ok),
    .clk_mismatch (clk_mismatch)
  );

  // ****************************************
  // Sticky flags
  // ****************************************
  logic [NUM_ALARMS-1:0] alarm_event;
  logic [NUM_ALARMS-1:0] status_r;
  logic [NUM_ALARMS-1:0] status_nxt;

  assign alarm_event[ALM_PLL]    = serdes_pll_unlocked;
  assign alarm_event[ALM_LINK]   = link_not_in_data;
  assign alarm_event[ALM_REALGN] = sysref_realign;
  assign alarm_event[ALM_OSC]    = osc_mismatch;
  assign alarm_event[ALM_CLK]    = clk_mismatch;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_ALARMS; gi++) begin : g_flag
      wire clr = clear_write && clear_data[gi];
      // Set wins over a clear in the same cycle; a zero write leaves the flag
      assign status_nxt[gi] = alarm_event[gi] || (status_r[gi] && !clr);
    end
  endgenerate

  wire [NUM_ALARMS-1:0] unmasked = status_nxt & ~alarm_mask;
  wire                  any_alarm = |unmasked;
  wire                  pin_nxt   = (status_pin_select == PIN_SEL_ALARM) && any_alarm;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_r               <= STATUS_RST;
      summary_alarm          <= 1'b0;
      calibration_status_pin <= 1'b0;
    end else begin
      status_r               <= status_nxt;
      summary_alarm          <= any_alarm;
      calibration_status_pin <= pin_nxt;
    end
  end

  // Flags are copied out of the flag register itself
  assign alarm_status_flags    = status_r;
  assign oscillator_upset_flag = status_r[ALM_OSC];
  assign clock_upset_flag      = status_r[ALM_CLK];

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_flag_sets_pll: assert property (
      serdes_pll_unlocked
      |=> alarm_status_flags[ALM_PLL])
    else $error("pll flag not set after event");
  a_flag_holds_sticky: assert property (
      alarm_status_flags[ALM_LINK] && !(clear_write && clear_data[ALM_LINK])
      |=> alarm_status_flags[ALM_LINK])
    else $error("link flag dropped without clear");
  a_clear_one_works: assert property (
      clear_write && clear_data[ALM_REALGN] && !sysref_realign
      |=> !alarm_status_flags[ALM_REALGN])
    else $error("realign flag not cleared by write of one");
  a_set_beats_clear: assert property (
      clear_write && clear_data[ALM_PLL] && serdes_pll_unlocked
      |=> alarm_status_flags[ALM_PLL])
    else $error("set lost to simultaneous clear");
  a_zero_write_noop: assert property (
      clear_write && !clear_data[ALM_CLK] && alarm_status_flags[ALM_CLK]
      |=> alarm_status_flags[ALM_CLK])
    else $error("zero write cleared clock flag");
  a_summary_masked: assert property (
      summary_alarm
      == |(alarm_status_flags & ~$past(alarm_mask)))
    else $error("summary does not match unmasked flags");
  a_pin_follows: assert property (
      calibration_status_pin
      == ($past(status_pin_select) && summary_alarm))
    else $error("status pin wrong");
  a_osc_mismatch_sets: assert property (
      compare_ok && osc_synced_r && (chan_a_phase_acc != chan_b_phase_acc)
      |=> oscillator_upset_flag)
    else $error("oscillator mismatch not flagged");
  a_osc_needs_sync: assert property (
      !osc_synced_r && !oscillator_upset_flag
      |=> !oscillator_upset_flag)
    else $error("oscillator flag set before sync");
  // The comparison must stay valid until the half-rate pair closes
  a_clk_mismatch_sets: assert property (
      compare_ok && (chan_a_clk_state != chan_b_clk_state) && !clock_upset_flag
      ##1 compare_ok ##1 compare_ok
      |-> ##[0:1] clock_upset_flag)
    else $error("clock mismatch not flagged within half-rate cycle");
  a_gate_no_upset: assert property (
      !compare_ok ##1 !compare_ok
      |-> !osc_mismatch && !clk_mismatch)
    else $error("upset reported without valid comparison");

  // ****************************************
  // Gating, sync and summary
  // ****************************************
  a_osc_gated: assert property (
      !compare_ok
      |-> !osc_mismatch)
    else $error("oscillator mismatch without valid comparison");
  a_clk_gated: assert property (
      !compare_ok
      |=> !clk_mismatch)
    else $error("clock mismatch without valid comparison");
  a_clk_half_rate: assert property (
      clk_mismatch
      |=> !clk_mismatch)
    else $error("clock mismatch longer than one pulse per pair");
  a_sync_lost: assert property (
      !compare_ok
      |=> !osc_synced_r)
    else $error("oscillator sync kept without valid comparison");
  a_sync_taken: assert property (
      compare_ok && sync_event
      |=> osc_synced_r)
    else $error("oscillator sync event not taken");
  a_pin_unselected: assert property (
      $past(status_pin_select) != PIN_SEL_ALARM
      |-> !calibration_status_pin)
    else $error("status pin high without alarm function");
  a_summary_idle: assert property (
      ~|alarm_status_flags
      |-> !summary_alarm)
    else $error("summary high with no flag set");

  // ****************************************
  // Per-flag checks
  // ****************************************
  // Every flag gets the same set, hold, clear and quiet checks
  a_set_link: assert property (
      alarm_event[ALM_LINK]
      |=> alarm_status_flags[ALM_LINK])
    else $error("link flag not set after event");
  a_set_realign: assert property (
      alarm_event[ALM_REALGN]
      |=> alarm_status_flags[ALM_REALGN])
    else $error("realign flag not set after event");
  a_set_osc: assert property (
      alarm_event[ALM_OSC]
      |=> alarm_status_flags[ALM_OSC])
    else $error("oscillator flag not set after event");
  a_set_clk: assert property (
      alarm_event[ALM_CLK]
      |=> alarm_status_flags[ALM_CLK])
    else $error("clock flag not set after event");

  a_hold_pll: assert property (
      alarm_status_flags[ALM_PLL] && !(clear_write && clear_data[ALM_PLL])
      |=> alarm_status_flags[ALM_PLL])
    else $error("pll flag dropped without clear");
  a_hold_realign: assert property (
      alarm_status_flags[ALM_REALGN] && !(clear_write && clear_data[ALM_REALGN])
      |=> alarm_status_flags[ALM_REALGN])
    else $error("realign flag dropped without clear");
  a_hold_osc: assert property (
      alarm_status_flags[ALM_OSC] && !(clear_write && clear_data[ALM_OSC])
      |=> alarm_status_flags[ALM_OSC])
    else $error("oscillator flag dropped without clear");
  a_hold_clk: assert property (
      alarm_status_flags[ALM_CLK] && !(clear_write && clear_data[ALM_CLK])
      |=> alarm_status_flags[ALM_CLK])
    else $error("clock flag dropped without clear");

  a_clear_pll: assert property (
      clear_write && clear_data[ALM_PLL] && !alarm_event[ALM_PLL]
      |=> !alarm_status_flags[ALM_PLL])
    else $error("pll flag not cleared by write of one");
  a_clear_link: assert property (
      clear_write && clear_data[ALM_LINK] && !alarm_event[ALM_LINK]
      |=> !alarm_status_flags[ALM_LINK])
    else $error("link flag not cleared by write of one");
  a_clear_osc: assert property (
      clear_write && clear_data[ALM_OSC] && !alarm_event[ALM_OSC]
      |=> !alarm_status_flags[ALM_OSC])
    else $error("oscillator flag not cleared by write of one");
  a_clear_clk: assert property (
      clear_write && clear_data[ALM_CLK] && !alarm_event[ALM_CLK]
      |=> !alarm_status_flags[ALM_CLK])
    else $error("clock flag not cleared by write of one");

  a_quiet_pll: assert property (
      !alarm_status_flags[ALM_PLL] && !alarm_event[ALM_PLL]
      |=> !alarm_status_flags[ALM_PLL])
    else $error("pll flag set without event");
  a_quiet_link: assert property (
      !alarm_status_flags[ALM_LINK] && !alarm_event[ALM_LINK]
      |=> !alarm_status_flags[ALM_LINK])
    else $error("link flag set without event");
  a_quiet_realign: assert property (
      !alarm_status_flags[ALM_REALGN] && !alarm_event[ALM_REALGN]
      |=> !alarm_status_flags[ALM_REALGN])
    else $error("realign flag set without event");
  a_quiet_osc: assert property (
      !alarm_status_flags[ALM_OSC] && !alarm_event[ALM_OSC]
      |=> !alarm_status_flags[ALM_OSC])
    else $error("oscillator flag set without event");
  a_quiet_clk: assert property (
      !alarm_status_flags[ALM_CLK] && !alarm_event[ALM_CLK]
      |=> !alarm_status_flags[ALM_CLK])
    else $error("clock flag set without event");

  c_osc_upset:  cover property (!oscillator_upset_flag ##1 oscillator_upset_flag);
  c_clk_upset:  cover property (!clock_upset_flag ##1 clock_upset_flag);
  c_set_clear:  cover property (clear_write && clear_data[ALM_PLL] && serdes_pll_unlocked);
  c_pin_high:   cover property (calibration_status_pin);

endmodule : aum_alarm_monitor

// *** tb_top.sv ***
// Self-checking testbench for the alarm and upset monitor
module tb_top
  import aum_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clock, rst_n, pll, lnk, rlg, sy_sr, sy_ls, link_en, pd_a, pd_b, sel, cwr;
  logic [ACC_W-1:0]      acc_a, acc_b;
  logic [CLK_W-1:0]      ck_a, ck_b;
  logic [NUM_ALARMS-1:0] mask, cdata, flags, ef;
  logic                  summ, pin, oflag, cflag;
  aum_sync_src_t         sy_src;
  int                    failures, n_compared, cycles, seed, i;
  logic [31:0]           r;
  aum_alarm_monitor DUT (.clock(clock), .rst_n(rst_n), .serdes_pll_unlocked(pll),
    .link_not_in_data(lnk), .sysref_realign(rlg), .chan_a_phase_acc(acc_a),
    .chan_b_phase_acc(acc_b), .osc_sync_sysref(sy_sr), .osc_sync_link_start(sy_ls),
    .osc_sync_source(sy_src), .chan_a_clk_state(ck_a), .chan_b_clk_state(ck_b),
    .serial_link_enable(link_en), .chan_a_power_down(pd_a), .chan_b_power_down(pd_b),
    .alarm_mask(mask), .status_pin_select(sel), .clear_write(cwr), .clear_data(cdata),
    .alarm_status_flags(flags), .summary_alarm(summ), .calibration_status_pin(pin),
    .oscillator_upset_flag(oflag), .clock_upset_flag(cflag));
  // ****************************************
  // Checking helpers
  // ****************************************
  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic check_all();
    #1;
    chk("flags", flags, ef);
    chk("summary", summ, |(ef & ~mask));
    chk("osc flag", oflag, ef[ALM_OSC]);
    chk("clk flag", cflag, ef[ALM_CLK]);
  endtask : check_all
  task automatic clear(logic [NUM_ALARMS-1:0] v, logic ev);
    @(posedge clock);
    cwr <= 1'b1;
    cdata <= v;
    pll <= ev;
    @(posedge clock);
    cwr <= 1'b0;
    pll <= 1'b0;
  endtask : clear
  task wrap_up();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up
  // ****************************************
  // Clock and timeout
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      wrap_up();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rst_n, pll, lnk, rlg, sy_sr, sy_ls, pd_a, pd_b, cwr} = '0;
    {acc_a, acc_b, ck_a, ck_b, mask, cdata, ef} = '0;
    {failures, n_compared, cycles} = '0;
    link_en = 1'b1;
    sel = PIN_SEL_ALARM;
    sy_src = AUM_SYNC_SYSREF;
    seed = 42;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    check_all();
    // Each plain source sets its own sticky bit, zero writes and racing clears do nothing
    for (i = 0; i < 3; i++) begin
      @(posedge clock);
      {rlg, lnk, pll} <= 3'b001 << i;
      mask <= '0;
      @(posedge clock);
      {rlg, lnk, pll} <= 3'b000;
      ef[i] = 1'b1;
      check_all();
      chk("pin", pin, 1'b1);
      r = $random(seed);
      mask <= r[NUM_ALARMS-1:0];
      clear(5'h0_0, 1'b0);
      check_all();
      clear(5'h0_1, i == 0);
      ef[0] = (i == 0);
      check_all();
      clear(5'h1_F, 1'b0);
      ef = '0;
      check_all();
    end
    $display("sticky source test done");
    // Oscillator compare counts only after sync, from either sync source
    mask <= '0;
    for (i = 0; i < 3; i++) begin
      @(posedge clock);
      r = $random(seed);
      acc_a <= r;
      acc_b <= r;
      if (i == 1) sy_sr <= 1'b1;
      if (i == 2) sy_ls <= 1'b1;
      if (i == 2) sy_src <= AUM_SYNC_LINK_START;
      @(posedge clock);
      {sy_sr, sy_ls} <= 2'b00;
      acc_b <= r ^ 32'h0000_0001;
      @(posedge clock);
      acc_b <= r;
      ef[ALM_OSC] = (i != 0);
      check_all();
      clear(5'h0_8, 1'b0);
      ef = '0;
      check_all();
    end
    // Link disabled together with channel B down hides both comparators
    @(posedge clock);
    link_en <= 1'b0;
    acc_b <= ~acc_a;
    pd_b <= 1'b1;
    ck_b <= ck_a ^ 4'h1;
    repeat (4) @(posedge clock);
    acc_b <= acc_a;
    ck_b <= ck_a;
    check_all();
    @(posedge clock);
    link_en <= 1'b1;
    pd_b <= 1'b0;
    repeat (4) @(posedge clock);
    clear(5'h1_8, 1'b0);
    ef = '0;
    check_all();
    // The link restart dropped the sync, so re-sync from lane alignment start
    @(posedge clock);
    sy_ls <= 1'b1;
    @(posedge clock);
    sy_ls <= 1'b0;
    acc_b <= acc_a ^ 32'h0000_0100;
    @(posedge clock);
    acc_b <= acc_a;
    ef[ALM_OSC] = 1'b1;
    check_all();
    clear(5'h0_8, 1'b0);
    ef = '0;
    check_all();
    $display("oscillator test done");
    // Clock difference lasting two device cycles sets the clock upset flag
    @(posedge clock);
    ck_b <= ck_a ^ 4'h8;
    repeat (2) @(posedge clock);
    ck_b <= ck_a;
    repeat (3) @(posedge clock);
    ef[ALM_CLK] = 1'b1;
    check_all();
    chk("pin", pin, 1'b1);
    clear(5'h1_0, 1'b0);
    ef = '0;
    check_all();
    $display("clock test done");
    wrap_up();
  end
endmodule : tb_top
